// ==== logic/quad_switch_regs.svh ====
// Constants of the quad switch serial diagnosis slave.
// Assumes inclusion by bare name from the design file.
`ifndef QUAD_SWITCH_REGS_SVH
`define QUAD_SWITCH_REGS_SVH

// ==========================================================
// Timing
`define CLK_PERIOD_NS 40
`define FAULT_FILTER_US 50
`define FAULT_FILTER_CYCLES ((`FAULT_FILTER_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ==========================================================
// Reset values
`define MATRIX_RESET 8'h00
`define FLAGS_RESET 12'h000

// ==========================================================
// Commands and diagnosis byte layout
`define SLEEP_CMD 8'hC0
`define CHAN_CODE_WIDTH 2
`define CODE_NONE 2'h0
`define CODE_OPEN_LOAD 2'h1
`define CODE_SHORT_GROUND 2'h2
`define CODE_PROTECTION 2'h3

`endif

// ==== logic/quad_switch_pkg.sv ====
// Types of the quad switch serial diagnosis slave.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package quad_switch_pkg;
  typedef struct packed {
    logic [3:0] overload_flag;
    logic [3:0] overtemp_flag;
    logic [3:0] open_load_flag;
    logic [3:0] short_ground_flag;
  } diag_in_type;

  typedef struct packed {
    logic [3:0] protection_flag;
    logic [3:0] open_load_flag;
    logic [3:0] short_ground_flag;
  } diag_flags_type;
endpackage

`default_nettype wire

// ==== logic/quad_switch_spi_diag_slave.sv ====
// Serial slave and diagnosis flag latching of a four-channel low-side switch.
// Assumes clk_i free running at 25 MHz; sclk_i runs only inside frames and is
// low at every chip select edge; fault conditions arrive asynchronously.
`include "quad_switch_regs.svh"
`default_nettype none

// ==========================================================
// Three-stage input synchroniser, change taken once stages agree
module input_sync (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q_o <= s3;
      end
    end
  end
endmodule // input_sync

// ==========================================================
// Persistence filter: high only after the input held for CYCLES
module fault_filter #(
  parameter int CYCLES = `FAULT_FILTER_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cond_i,
  output logic hit_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);
  logic [CW-1:0] count;
  wire reached = (count == LIMIT);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= '0;
    end else if (!cond_i) begin
      count <= '0;
    end else if (!reached) begin
      count <= count + CW'(1);
    end
  end
  assign hit_o = reached;
endmodule // fault_filter

// Behaviour
// - protection flag is overload or overtemperature
// - open-load result latched per channel
// - short-to-ground result latched per channel
// - non-temperature faults must persist filter time
// - flags stay latched until successful transfer
// - access starts on chip select falling
// - sample input falling, drive output rising
// - accept only multiples of eight bits
// - chip select high ignores clock, output off
// - chip select falling loads diagnosis byte
// - good rising edge decodes, copies to matrix
// - good rising edge clears flags not set again that cycle
// - eight-bit words, MSB first
// - output MSB first, driven only when selected
// - power-on reset or sleep restores defaults
// - one eight-bit chainable shift register
// - fault output low on any diagnosed error
module quad_switch_spi_diag_slave
  import quad_switch_pkg::*;
#(
  parameter int FILTER_CYCLES = `FAULT_FILTER_CYCLES
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire diag_in_type diag_i,
  output diag_flags_type flags_o,
  output logic [7:0] input_matrix_o,
  output logic matrix_valid_o,
  output logic sleep_o,
  output logic fault_out_o,
  output logic fault_oe_o
);

  // ==========================================================
  // Reset release
  logic rst_q1;
  logic rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_q1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_q1 <= 1'b1;
      rst_n <= rst_q1;
    end
  end

  // ==========================================================
  // Link domain: shift register and bit counting
  logic [7:0] snap;
  logic [7:0] shift;
  logic [2:0] bit_count;
  logic started;
  logic ok_hold;
  logic frame_tog;
  logic so_reg;

  // first bit of frame taken from snapshot
  // eight bits, MSB first, shifted in at bit 0
  wire [7:0] next_shift = started ? {shift[6:0], si_i} : {snap[6:0], si_i};

  always_ff @(negedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      bit_count <= 3'h0;
      started <= 1'b0;
    end else begin
      bit_count <= bit_count + 3'h1;
      started <= 1'b1;
    end
  end

  always_ff @(negedge sclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shift <= 8'h00;
      ok_hold <= 1'b0;
      frame_tog <= 1'b0;
    end else if (!cs_n_i) begin
      shift <= next_shift;
      ok_hold <= (bit_count == 3'h7);
      if (!started) begin
        frame_tog <= ~frame_tog;
      end
    end
  end

  always_ff @(posedge sclk_i or posedge cs_n_i) begin
    if (cs_n_i) begin
      so_reg <= 1'b0;
    end else begin
      so_reg <= started ? shift[7] : snap[7];
    end
  end

  // MSB first, enabled only while selected
  assign so_o = started ? so_reg : snap[7];
  assign so_oe_o = ~cs_n_i;

  // ==========================================================
  // Crossings into the system domain
  logic cs_n_s;
  logic cs_sel_s;
  logic tog_s;
  // Select synchronised as active high so its reset value matches the idle pin
  wire cs_sel_i = ~cs_n_i;
  input_sync u_cs_sync (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(cs_sel_i), .q_o(cs_sel_s));
  assign cs_n_s = ~cs_sel_s;
  input_sync u_tog_sync (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(frame_tog), .q_o(tog_s));

  logic cs_prev;
  logic tog_at_start;
  wire cs_fall = cs_prev & ~cs_n_s;
  wire cs_rise = ~cs_prev & cs_n_s;
  // clocked frame with whole bytes; shift and ok_hold are stable since the last edge
  wire frame_ok = cs_rise & (tog_s != tog_at_start) & ok_hold;
  wire sleep_hit = frame_ok & (shift == `SLEEP_CMD);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev <= 1'b1;
      tog_at_start <= 1'b0;
    end else begin
      cs_prev <= cs_n_s;
      if (cs_fall) begin
        tog_at_start <= tog_s;
      end
    end
  end

  // ==========================================================
  // Fault inputs: synchronise, filter all but overtemperature, latch
  diag_in_type diag_s;
  logic [3:0] ovl_hit;
  logic [3:0] ol_hit;
  logic [3:0] sg_hit;

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_chan
      input_sync u_ovl_s (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(diag_i.overload_flag[ch]),
                          .q_o(diag_s.overload_flag[ch]));
      input_sync u_ot_s (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(diag_i.overtemp_flag[ch]),
                         .q_o(diag_s.overtemp_flag[ch]));
      input_sync u_ol_s (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(diag_i.open_load_flag[ch]),
                         .q_o(diag_s.open_load_flag[ch]));
      input_sync u_sg_s (.clk_i(clk_i), .rst_n_i(rst_n), .d_i(diag_i.short_ground_flag[ch]),
                         .q_o(diag_s.short_ground_flag[ch]));
      fault_filter #(.CYCLES(FILTER_CYCLES)) u_ovl_f (.clk_i(clk_i), .rst_n_i(rst_n),
        .cond_i(diag_s.overload_flag[ch]), .hit_o(ovl_hit[ch]));
      fault_filter #(.CYCLES(FILTER_CYCLES)) u_ol_f (.clk_i(clk_i), .rst_n_i(rst_n),
        .cond_i(diag_s.open_load_flag[ch]), .hit_o(ol_hit[ch]));
      fault_filter #(.CYCLES(FILTER_CYCLES)) u_sg_f (.clk_i(clk_i), .rst_n_i(rst_n),
        .cond_i(diag_s.short_ground_flag[ch]), .hit_o(sg_hit[ch]));
    end
  endgenerate

  wire [3:0] prot_set = ovl_hit | diag_s.overtemp_flag;
  diag_flags_type flags;
  diag_flags_type next_flags;

  // hold until cleared; clear on good frame, new events win
  always_comb begin
    next_flags = frame_ok ? diag_flags_type'(`FLAGS_RESET) : flags;
    next_flags.protection_flag = next_flags.protection_flag | prot_set;
    next_flags.open_load_flag = next_flags.open_load_flag | ol_hit;
    next_flags.short_ground_flag = next_flags.short_ground_flag | sg_hit;
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      flags <= diag_flags_type'(`FLAGS_RESET);
    end else if (sleep_hit) begin
      flags <= diag_flags_type'(`FLAGS_RESET);
    end else begin
      flags <= next_flags;
    end
  end
  assign flags_o = flags;

  // ==========================================================
  // Diagnosis byte, two bits per channel, channel 3 highest
  logic [7:0] diag_byte;
  always_comb begin
    diag_byte = 8'h00;
    for (int i = 0; i < 4; i++) begin
      if (flags.protection_flag[i]) begin
        diag_byte[i*2 +: 2] = `CODE_PROTECTION;
      end else if (flags.short_ground_flag[i]) begin
        diag_byte[i*2 +: 2] = `CODE_SHORT_GROUND;
      end else if (flags.open_load_flag[i]) begin
        diag_byte[i*2 +: 2] = `CODE_OPEN_LOAD;
      end else begin
        diag_byte[i*2 +: 2] = `CODE_NONE;
      end
    end
  end

  // snapshot frozen from chip select falling
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      snap <= 8'h00;
    end else if (cs_n_s) begin
      snap <= diag_byte;
    end
  end

  // ==========================================================
  // Input matrix and command decode
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      input_matrix_o <= `MATRIX_RESET;
      matrix_valid_o <= 1'b0;
      sleep_o <= 1'b0;
    end else begin
      matrix_valid_o <= frame_ok & ~sleep_hit;
      sleep_o <= sleep_hit;
      if (sleep_hit) begin
        input_matrix_o <= `MATRIX_RESET;
      end else if (frame_ok) begin
        input_matrix_o <= shift;
      end
    end
  end

  // open-drain fault pulled low on any flag
  assign fault_out_o = 1'b0;
  assign fault_oe_o = |flags;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_good_end;
    frame_ok && !sleep_hit;
  endsequence

  property p_prot_ovl;
    $rose(ovl_hit[0]) |=> flags.protection_flag[0];
  endproperty
  a_prot_ovl: assert property (p_prot_ovl) else $error("overload did not set protection");

  property p_overtemp_now;
    diag_s.overtemp_flag[1] && !sleep_hit |=> flags.protection_flag[1];
  endproperty
  a_overtemp_now: assert property (p_overtemp_now) else $error("overtemp not latched at once");

  property p_ol_filtered;
    $rose(flags.open_load_flag[2]) |-> $past(ol_hit[2]);
  endproperty
  a_ol_filtered: assert property (p_ol_filtered) else $error("open load set without filter");

  property p_sg_latch;
    sg_hit[3] && !sleep_hit |=> flags.short_ground_flag[3];
  endproperty
  a_sg_latch: assert property (p_sg_latch) else $error("short to ground not latched");

  property p_hold;
    !frame_ok && !sleep_hit |=> (flags | $past(flags)) == flags;
  endproperty
  a_hold: assert property (p_hold) else $error("flag lost without clear");

  property p_clear;
    s_good_end ##0 (prot_set == 4'h0 && ol_hit == 4'h0 && sg_hit == 4'h0) |=> flags == `FLAGS_RESET;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared after transfer");

  property p_matrix;
    s_good_end |=> input_matrix_o == $past(shift) ##0 matrix_valid_o;
  endproperty
  a_matrix: assert property (p_matrix) else $error("matrix not loaded");

  property p_reject;
    cs_rise && !frame_ok |=> $stable(input_matrix_o) && !matrix_valid_o;
  endproperty
  a_reject: assert property (p_reject) else $error("partial frame accepted");

  property p_snap_frozen;
    !cs_n_s && !$past(cs_n_s) |-> $stable(snap);
  endproperty
  a_snap_frozen: assert property (p_snap_frozen) else $error("snapshot moved in frame");

  property p_sleep;
    sleep_hit |=> input_matrix_o == `MATRIX_RESET && sleep_o && flags == `FLAGS_RESET;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not restore defaults");

  property p_fault;
    (flags != `FLAGS_RESET) |-> fault_oe_o && !fault_out_o;
  endproperty
  a_fault: assert property (p_fault) else $error("fault pin not pulled low");

  property p_so_off;
    cs_n_i |-> !so_oe_o;
  endproperty
  a_so_off: assert property (p_so_off) else $error("serial output driven while deselected");

endmodule // quad_switch_spi_diag_slave

`default_nettype wire

// ==== verification/spi_master_model.sv ====
// Host side serial master model for the quad switch diagnosis slave.
// Assumes a free running link base clock; frames are started by calling xfer.
`default_nettype none

module spi_master_model (
  input wire logic lclk_i,
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic oe_ok;

  // ==========================================================
  // Idle levels: select pulled up, clock and data pulled down
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
    oe_ok = 1'b1;
  end

  // ==========================================================
  // One frame of n bits, half clock period of seven base ticks
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    oe_ok = 1'b1;
    @(posedge lclk_i);
    cs_n_o <= 1'b0;
    repeat (20) @(posedge lclk_i);
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o <= 1'b1;
      si_o <= tx[i];
      repeat (7) @(posedge lclk_i);
      sclk_o <= 1'b0;
      rx = {rx[30:0], so_i};
      oe_ok = oe_ok & so_oe_i;
      repeat (7) @(posedge lclk_i);
    end
    repeat (13) @(posedge lclk_i);
    cs_n_o <= 1'b1;
    si_o <= 1'b0;
  endtask
endmodule // spi_master_model

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the quad switch serial diagnosis slave.
// Assumes the design package and the master model are compiled first.
`default_nettype none

module testbench;
  import quad_switch_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int FILT = 20;
  logic clk_i = 1'b0;
  logic lclk = 1'b0;
  logic reset_n_i = 1'b0;
  logic sclk_i;
  logic cs_n_i;
  logic si_i;
  logic so_o;
  logic so_oe_o;
  diag_in_type diag_i = '0;
  diag_flags_type flags_o;
  logic [7:0] input_matrix_o;
  logic matrix_valid_o;
  logic sleep_o;
  logic fault_out_o;
  logic fault_oe_o;
  int error_cnt = 0;
  int tests_run = 0;

  always #20 clk_i = ~clk_i;
  always #7.5 lclk = ~lclk;

  quad_switch_spi_diag_slave #(.FILTER_CYCLES(FILT)) DUT (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i),
    .so_o(so_o), .so_oe_o(so_oe_o), .diag_i(diag_i), .flags_o(flags_o),
    .input_matrix_o(input_matrix_o), .matrix_valid_o(matrix_valid_o), .sleep_o(sleep_o),
    .fault_out_o(fault_out_o), .fault_oe_o(fault_oe_o)
  );

  spi_master_model model (
    .lclk_i(lclk), .so_i(so_o), .so_oe_i(so_oe_o), .sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i)
  );

  // ==========================================================
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // Frame plus count of accept and sleep pulses after it
  task automatic frame(input int n, input logic [31:0] tx, input logic [31:0] rexp, input int vexp,
                       input int sexp);
    logic [31:0] rx;
    int v;
    int s;
    v = 0;
    s = 0;
    model.xfer(n, tx, rx);
    for (int k = 0; k < 12; k++) begin
      @(posedge clk_i);
      #1;
      v += int'(matrix_valid_o === 1'b1);
      s += int'(sleep_o === 1'b1);
    end
    check(rx, rexp);
    check({31'h0, model.oe_ok}, 32'h1);
    check(v, vexp);
    check(s, sexp);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    #1;
    check({flags_o, input_matrix_o, so_oe_o, fault_oe_o, fault_out_o}, 32'h0);
    frame(8, 32'h5A, 32'h00, 1, 0);
    check(input_matrix_o, 8'h5A);
    // Overtemp ch0, overload ch3, open load ch1, short and open load ch2
    @(posedge clk_i);
    diag_i <= '{overload_flag: 4'h8, overtemp_flag: 4'h1, open_load_flag: 4'h6, short_ground_flag: 4'h4};
    repeat (10) @(posedge clk_i);
    #1;
    check(flags_o, {4'h1, 4'h0, 4'h0});
    check(fault_oe_o, 1'b1);
    repeat (30) @(posedge clk_i);
    #1;
    check(flags_o, {4'h9, 4'h6, 4'h4});
    @(posedge clk_i);
    diag_i <= '0;
    repeat (5) @(posedge clk_i);
    frame(7, 32'h11, 32'h73, 0, 0);
    check(flags_o, {4'h9, 4'h6, 4'h4});
    frame(8, 32'h11, 32'hE7, 1, 0);
    check(flags_o, 12'h000);
    check(fault_oe_o, 1'b0);
    frame(16, 32'h3CA5, 32'h003C, 1, 0);
    check(input_matrix_o, 8'hA5);
    @(posedge clk_i);
    diag_i.overtemp_flag <= 4'h4;
    repeat (10) @(posedge clk_i);
    diag_i <= '0;
    repeat (5) @(posedge clk_i);
    frame(8, 32'hC0, 32'h30, 0, 1);
    check({flags_o, input_matrix_o}, 32'h0);
    final_report();
  end
endmodule // testbench

`default_nettype wire
